// ---- src/jtag_run_control_chain.v ----
// control and setup scan chains loaded over jtag, decoded on the core clock
`timescale 1ns/10ps
`default_nettype none
`include "jtag_run_control_chain_consts.vh"

module jtag_run_control_chain #(
  parameter CTRL_W = `CTRL_LEN,
  parameter SETUP_W = `SETUP_LEN,
  parameter NUM_CH = 32
) (
  // core clock and reset
  input wire core_clk,
  input wire nrst,
  // jtag pins and tap decode; inputs asynchronous to core_clk, jtag_tdo registered on core_clk
  input wire jtag_tck,
  input wire jtag_tdi,
  input wire jtag_trst_n,
  input wire sel_control,
  input wire sel_setup,
  input wire capture_dr,
  input wire shift_dr,
  input wire update_dr,
  output wire jtag_tdo,
  // edge enables from elsewhere in the setup logic, core domain
  input wire lead_en_cfg,
  input wire trail_en_cfg,
  // decoded control outputs
  output wire readout_drv_en,
  output wire power_up,
  output wire global_reset,
  output wire [NUM_CH-1:0] channel_en,
  output wire dll_reset,
  output wire pll_reset,
  output wire ctrl_parity_err,
  // decoded setup outputs
  output wire match_en,
  output wire pair_en,
  output wire lead_en,
  output wire trail_en,
  output wire setup_parity_err
);

  // ----------------------------------------------------------------------
  // two-flop synchronisers
  // ----------------------------------------------------------------------
  reg [`SYN_W-1:0] sync1_ff;
  reg [`SYN_W-1:0] sync2_ff;
  reg tck_d_ff;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= `SYN_RST_VAL;
      sync2_ff <= `SYN_RST_VAL;
      tck_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {update_dr, shift_dr, capture_dr, sel_setup, sel_control,
                   jtag_trst_n, jtag_tdi, jtag_tck};
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff[`SYN_TCK];
    end
  end

  wire tck_rise;
  wire tdi_s;
  wire trst_act;
  wire do_capture;
  wire do_shift;
  wire do_update;
  wire on_ctrl;
  wire on_setup;

  assign tck_rise = sync2_ff[`SYN_TCK] & ~tck_d_ff;
  assign tdi_s = sync2_ff[`SYN_TDI];
  assign trst_act = ~sync2_ff[`SYN_TRST_N];
  assign on_ctrl = sync2_ff[`SYN_SEL_CTRL];
  assign on_setup = sync2_ff[`SYN_SEL_SETUP] & ~on_ctrl;
  assign do_capture = tck_rise & sync2_ff[`SYN_CAPTURE];
  assign do_shift = tck_rise & sync2_ff[`SYN_SHIFT];
  assign do_update = tck_rise & sync2_ff[`SYN_UPDATE];

  // ----------------------------------------------------------------------
  // control chain: shift stage and stored image
  // ----------------------------------------------------------------------
  reg [CTRL_W-1:0] ctrl_sh_ff;
  reg [CTRL_W-1:0] ctrl_ff;
  reg [CTRL_W-1:0] nxt_ctrl_sh;
  reg [CTRL_W-1:0] nxt_ctrl;

  always @* begin
    nxt_ctrl_sh = ctrl_sh_ff;
    nxt_ctrl = ctrl_ff;
    if (on_ctrl && do_capture) begin
      nxt_ctrl_sh = ctrl_ff;
    end else if (on_ctrl && do_shift) begin
      nxt_ctrl_sh = {tdi_s, ctrl_sh_ff[CTRL_W-1:1]};
    end
    // update taken at any time, no run stop needed [R6]
    if (on_ctrl && do_update) begin
      nxt_ctrl = ctrl_sh_ff; // [R6]
    end
    // test reset holds the unlock msb high [R9]
    if (trst_act) begin
      nxt_ctrl[`CTRL_UNLOCK_MSB] = 1'b1; // [R9]
    end
  end

  // global reset from bit 4 does not clear this image, so the loop
  // reset bits keep their value through it [R15]
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_sh_ff <= `CTRL_RST_VAL;
      ctrl_ff <= `CTRL_RST_VAL;
    end else begin
      ctrl_sh_ff <= nxt_ctrl_sh;
      ctrl_ff <= nxt_ctrl; // [R15]
    end
  end

  // ----------------------------------------------------------------------
  // setup chain: shift stage and stored image
  // ----------------------------------------------------------------------
  reg [SETUP_W-1:0] setup_sh_ff;
  reg [SETUP_W-1:0] setup_ff;
  reg [SETUP_W-1:0] nxt_setup_sh;
  reg [SETUP_W-1:0] nxt_setup;

  always @* begin
    nxt_setup_sh = setup_sh_ff;
    nxt_setup = setup_ff;
    if (on_setup && do_capture) begin
      nxt_setup_sh = setup_ff;
    end else if (on_setup && do_shift) begin
      nxt_setup_sh = {tdi_s, setup_sh_ff[SETUP_W-1:1]};
    end
    if (on_setup && do_update) begin
      nxt_setup = setup_sh_ff;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      setup_sh_ff <= {SETUP_W{1'b0}};
      setup_ff <= {SETUP_W{1'b0}};
    end else begin
      setup_sh_ff <= nxt_setup_sh;
      setup_ff <= nxt_setup;
    end
  end

  // ----------------------------------------------------------------------
  // serial output, lsb of the selected chain
  // ----------------------------------------------------------------------
  reg tdo_ff;
  reg nxt_tdo;

  always @* begin
    nxt_tdo = tdo_ff;
    if (on_ctrl) begin
      nxt_tdo = nxt_ctrl_sh[0];
    end else if (on_setup) begin
      nxt_tdo = nxt_setup_sh[0];
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tdo_ff <= 1'b0;
    end else begin
      tdo_ff <= nxt_tdo;
    end
  end

  assign jtag_tdo = tdo_ff;

  // ----------------------------------------------------------------------
  // decoded control outputs
  // ----------------------------------------------------------------------
  reg drv_en_ff;
  reg pwr_up_ff;
  reg grst_ff;
  reg [NUM_CH-1:0] chan_en_ff;
  reg dll_rst_ff;
  reg pll_rst_ff;
  reg ctrl_perr_ff;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drv_en_ff <= 1'b0;
      pwr_up_ff <= 1'b0;
      grst_ff <= 1'b0;
      chan_en_ff <= {NUM_CH{1'b0}};
      dll_rst_ff <= 1'b0;
      pll_rst_ff <= 1'b0;
      ctrl_perr_ff <= 1'b0;
    end else begin
      drv_en_ff <= (ctrl_ff[`CTRL_UNLOCK_MSB:`CTRL_UNLOCK_LSB] == `UNLOCK_DRV_CODE); // [R7]
      pwr_up_ff <= (ctrl_ff[`CTRL_UNLOCK_MSB:`CTRL_PWR_LSB] == `UNLOCK_PWR_CODE); // [R8]
      // level follows the bit; loader clears it to end the reset [R10]
      grst_ff <= ctrl_ff[`CTRL_GRST_BIT]; // [R10] [R11]
      chan_en_ff <= ctrl_ff[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB]; // [R12]
      dll_rst_ff <= ctrl_ff[`CTRL_DLL_RST_BIT]; // [R13]
      pll_rst_ff <= ctrl_ff[`CTRL_PLL_RST_BIT]; // [R13]
      // odd count of ones over all 40 bits, parity bit included [R14] [R18]
      ctrl_perr_ff <= ^ctrl_ff; // [R18]
    end
  end

  assign readout_drv_en = drv_en_ff;
  assign power_up = pwr_up_ff;
  // shares the pin reset's reach in the global logic it feeds [R11]
  assign global_reset = grst_ff;
  assign channel_en = chan_en_ff;
  assign dll_reset = dll_rst_ff;
  assign pll_reset = pll_rst_ff;
  assign ctrl_parity_err = ctrl_perr_ff;

  // ----------------------------------------------------------------------
  // decoded setup outputs
  // ----------------------------------------------------------------------
  reg match_ff;
  reg pair_ff;
  reg lead_ff;
  reg trail_ff;
  reg setup_perr_ff;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      match_ff <= 1'b0;
      pair_ff <= 1'b0;
      lead_ff <= 1'b0;
      trail_ff <= 1'b0;
      setup_perr_ff <= 1'b0;
    end else begin
      match_ff <= setup_ff[`SETUP_MATCH_BIT]; // [R1]
      pair_ff <= setup_ff[`SETUP_PAIR_BIT]; // [R2]
      // pairing overrides the separate edge enables [R3]
      lead_ff <= lead_en_cfg & ~setup_ff[`SETUP_PAIR_BIT]; // [R3]
      trail_ff <= trail_en_cfg & ~setup_ff[`SETUP_PAIR_BIT]; // [R3]
      setup_perr_ff <= ^setup_ff; // [R5]
    end
  end

  assign match_en = match_ff;
  assign pair_en = pair_ff;
  assign lead_en = lead_ff;
  assign trail_en = trail_ff;
  assign setup_parity_err = setup_perr_ff;

endmodule // jtag_run_control_chain

`default_nettype wire

// ---- src/jtag_run_control_chain_consts.vh ----
// constants for the run-control and setup scan chain decoder
//
// Functional notes
// R1: setup bit 639 high enables trigger matching, low disables it.
// R2: setup bit 640 high pairs each leading edge with its trailing edge.
// R3: while pairing is on, separate leading and trailing enables are ignored.
// R4: loader must not enable pairing in very high resolution mode.
// R5: setup bit 646 is even parity; loader makes total ones even.
// R6: control chain updates apply at any time, also while running.
// R7: control bits 3..0 equal to 0101 enable readout bus drivers.
// R8: bits 3..1 equal to 010 leave power-down; bit 0 ignored.
// R9: test reset forces unlock bit 3 to one.
// R10: control bit 4 is global reset; loader writes one then zero.
// R11: chain global reset acts like the external reset pin.
// R12: control bits 36..5 enable the 32 channels one by one.
// R13: bit 37 resets delay loop, bit 38 phase loop; pulse after power-up.
// R14: control bit 39 is even parity; loader makes total ones even.
// R15: global reset leaves the phase and delay loop resets untouched.
// R16: loader resets phase loop, waits for lock, then delay loop.
// R17: loader loads loop parameters in setup before pulsing loop resets.
// R18: stored control chain is checked against its parity continuously.
`ifndef JTAG_RUN_CONTROL_CHAIN_CONSTS_VH
`define JTAG_RUN_CONTROL_CHAIN_CONSTS_VH

// ----------------------------------------------------------------------
// chain lengths
// ----------------------------------------------------------------------
`define CTRL_LEN 40
`define SETUP_LEN 647

// ----------------------------------------------------------------------
// control chain fields
// ----------------------------------------------------------------------
`define CTRL_UNLOCK_MSB 3
`define CTRL_UNLOCK_LSB 0
`define CTRL_GRST_BIT 4
`define CTRL_CHAN_MSB 36
`define CTRL_CHAN_LSB 5
`define CTRL_DLL_RST_BIT 37
`define CTRL_PLL_RST_BIT 38
`define CTRL_PARITY_BIT 39
`define CTRL_RST_VAL 40'h0000000008
`define UNLOCK_DRV_CODE 4'h5
`define UNLOCK_PWR_CODE 3'h2
`define CTRL_PWR_LSB 1

// ----------------------------------------------------------------------
// setup chain fields
// ----------------------------------------------------------------------
`define SETUP_MATCH_BIT 639
`define SETUP_PAIR_BIT 640
`define SETUP_PARITY_BIT 646

// ----------------------------------------------------------------------
// synchroniser lanes
// ----------------------------------------------------------------------
`define SYN_TCK 0
`define SYN_TDI 1
`define SYN_TRST_N 2
`define SYN_SEL_CTRL 3
`define SYN_SEL_SETUP 4
`define SYN_CAPTURE 5
`define SYN_SHIFT 6
`define SYN_UPDATE 7
`define SYN_W 8
`define SYN_RST_VAL 8'h04

`endif

// ---- tb/jtag_run_control_chain_properties.sv ----
// port assertions for the run-control chain decoder
`timescale 1ns/10ps
`default_nettype none
module run_chain_checker #(
  parameter NUM_CH = 32
) (
  // clock, reset, jtag side
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic jtag_trst_n,
  input wire logic sel_control,
  input wire logic sel_setup,
  input wire logic update_dr,
  input wire logic jtag_tdo,
  // decoded side
  input wire logic lead_en_cfg,
  input wire logic trail_en_cfg,
  input wire logic readout_drv_en,
  input wire logic power_up,
  input wire logic global_reset,
  input wire logic [NUM_CH-1:0] channel_en,
  input wire logic match_en,
  input wire logic pair_en,
  input wire logic lead_en,
  input wire logic trail_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_drv_pwr; readout_drv_en |-> power_up; endproperty
  a_drv_pwr: assert property (p_drv_pwr) else $error("drivers on in power-down");
  property p_trst_drv; $fell(jtag_trst_n) |-> ##[1:5] !readout_drv_en; endproperty
  a_trst_drv: assert property (p_trst_drv) else $error("test reset left drivers on");
  property p_trst_pwr; !jtag_trst_n [*8] |-> !power_up; endproperty
  a_trst_pwr: assert property (p_trst_pwr) else $error("test reset left power-up");
  property p_pair_mask; pair_en |-> !lead_en && !trail_en; endproperty
  a_pair_mask: assert property (p_pair_mask) else $error("edge enable under pairing");
  property p_edge_cfg;
    $past(nrst) |-> lead_en == ($past(lead_en_cfg) && !pair_en)
      && trail_en == ($past(trail_en_cfg) && !pair_en);
  endproperty
  a_edge_cfg: assert property (p_edge_cfg) else $error("edge enable mismatch");
  property p_chan_hold;
    !update_dr [*8] |-> $stable(channel_en) && $stable(global_reset);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("control changed sans update");
  property p_setup_hold; !update_dr [*8] |-> $stable(match_en) && $stable(pair_en); endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup changed sans update");
  property p_tdo_hold; (!sel_control && !sel_setup) [*8] |-> $stable(jtag_tdo); endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while idle");
  c_drv: cover property ($rose(readout_drv_en));
  c_pair: cover property ($rose(pair_en));
  c_grst: cover property ($rose(global_reset));
endmodule // run_chain_checker
bind jtag_run_control_chain run_chain_checker #(.NUM_CH(NUM_CH)) u_chk (.core_clk(core_clk),
  .nrst(nrst), .jtag_trst_n(jtag_trst_n), .sel_control(sel_control),
  .sel_setup(sel_setup), .update_dr(update_dr), .jtag_tdo(jtag_tdo),
  .lead_en_cfg(lead_en_cfg), .trail_en_cfg(trail_en_cfg),
  .readout_drv_en(readout_drv_en), .power_up(power_up), .global_reset(global_reset),
  .channel_en(channel_en), .match_en(match_en), .pair_en(pair_en), .lead_en(lead_en),
  .trail_en(trail_en));
`default_nettype wire

// ---- tb/jtag_tap_model.sv ----
// jtag test controller model loading the scan chains
`timescale 1ns/10ps
`default_nettype none
module jtag_tap_model (
  // jtag pins
  output logic tck,
  output logic tdi,
  output logic sel_control,
  output logic sel_setup,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  input wire logic tdo
);
  initial {tck, tdi, sel_control, sel_setup, capture_dr, shift_dr, update_dr} = 7'h00;
  task automatic pulse();
    #160 tck = 1'b1;
    #160 tck = 1'b0;
  endtask
  // capture, shift lsb first, update; q gets the old image
  task automatic scan(input bit ctl, input int n, input logic [646:0] d,
                      output logic [646:0] q);
    q = '0;
    sel_control = ctl;
    sel_setup = !ctl;
    capture_dr = 1'b1;
    pulse();
    capture_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi = d[i];
      #160 q[i] = tdo;
      tck = 1'b1;
      #160 tck = 1'b0;
    end
    shift_dr = 1'b0;
    update_dr = 1'b1;
    pulse();
    {update_dr, sel_control, sel_setup} = 3'h0;
    tdi = !tdi;
  endtask
endmodule // jtag_tap_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the run-control chain
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic jtag_trst_n = 1'b1;
  logic lead_en_cfg = 1'b0;
  logic trail_en_cfg = 1'b0;
  wire jtag_tck, jtag_tdi, jtag_tdo, sel_control, sel_setup, capture_dr, shift_dr, update_dr;
  wire readout_drv_en, power_up, global_reset, dll_reset, pll_reset, ctrl_parity_err;
  wire match_en, pair_en, lead_en, trail_en, setup_parity_err;
  wire [31:0] channel_en;
  logic [646:0] d;
  logic [646:0] q;
  logic [39:0] pv = 40'h0000000008;
  logic [38:0] tbl [6] = '{39'h40_0000_0005, 39'h00_0000_0005, 39'h20_0000_0003,
                           39'h14_B4A1_E025, 39'h54_B4A1_E035, 39'h14_B4A1_E025};
  int num_errors = 0;
  int checks_done = 0;
  initial forever #20 core_clk = !core_clk;
  jtag_tap_model tap (.tck(jtag_tck), .tdi(jtag_tdi), .sel_control(sel_control),
    .sel_setup(sel_setup), .capture_dr(capture_dr), .shift_dr(shift_dr),
    .update_dr(update_dr), .tdo(jtag_tdo));
  jtag_run_control_chain uut (.core_clk(core_clk), .nrst(nrst), .jtag_tck(jtag_tck),
    .jtag_tdi(jtag_tdi), .jtag_trst_n(jtag_trst_n), .sel_control(sel_control),
    .sel_setup(sel_setup), .capture_dr(capture_dr), .shift_dr(shift_dr),
    .update_dr(update_dr), .jtag_tdo(jtag_tdo), .lead_en_cfg(lead_en_cfg),
    .trail_en_cfg(trail_en_cfg), .readout_drv_en(readout_drv_en), .power_up(power_up),
    .global_reset(global_reset), .channel_en(channel_en), .dll_reset(dll_reset),
    .pll_reset(pll_reset), .ctrl_parity_err(ctrl_parity_err), .match_en(match_en),
    .pair_en(pair_en), .lead_en(lead_en), .trail_en(trail_en),
    .setup_parity_err(setup_parity_err));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge core_clk);
    #2;
  endtask
  task automatic stp(input logic m, input logic p);
    d = '0;
    d[640:639] = {p, m};
    d[646] = m ^ p;
    tap.scan(1'b0, 647, d, q);
    settle();
    chk({match_en, pair_en, setup_parity_err}, {m, p, 1'b0});
    chk({lead_en, trail_en}, {lead_en_cfg & !p, trail_en_cfg & !p});
  endtask
  task automatic ctl(input logic [38:0] v, input bit bad);
    d = '0;
    d[39:0] = {^v ^ bad, v};
    tap.scan(1'b1, 40, d, q);
    settle();
    chk(q[39:0], pv);
    pv = d[39:0];
    chk({readout_drv_en, power_up}, {v[3:0] == 4'h5, v[3:1] == 3'h2});
    chk({global_reset, dll_reset, pll_reset}, {v[4], v[37], v[38]});
    chk(channel_en, v[36:5]);
    chk(ctrl_parity_err, bad);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #2 nrst = 1'b1;
    settle();
    chk({readout_drv_en, power_up, channel_en, ctrl_parity_err}, 35'h1);
    {lead_en_cfg, trail_en_cfg} = 2'h3;
    stp(1'b1, 1'b0);
    stp(1'b0, 1'b1);
    chk(q[640:639], 2'h1);
    trail_en_cfg = 1'b0;
    foreach (tbl[i]) ctl(tbl[i], 1'b0);
    jtag_trst_n = 1'b0;
    settle();
    chk({readout_drv_en, power_up, ctrl_parity_err}, 3'h1);
    jtag_trst_n = 1'b1;
    settle();
    chk(readout_drv_en, 1'b0);
    pv[3] = 1'b1;
    ctl(39'h00_0000_0005, 1'b1);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
